// File: core/null_avg_cfg.svh
`ifndef NULL_AVG_CFG_SVH
`define NULL_AVG_CFG_SVH

// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_WINDOW    8'h04
`define OFS_STATUS    8'h08
`define OFS_OFFSET    8'h0C
`define OFS_RESULT    8'h10
`define CTRL_W        15
`define WIN_W         7

// Reset values and window limits
`define WIN_RST       7'h0A
`define WIN_MIN       7'h02
`define WIN_MAX       7'h64
`define INTEG_RST     4'h8
`define FUNC_RST      4'h0

// Integration codes (0.001 .. 100 line cycles)
`define INTEG_P001    4'h0
`define INTEG_P02     4'h2

// Function codes
`define FN_ACV        4'h4
`define FN_ACI        4'h5
`define FN_FREQ       4'h6
`define FN_PER        4'h7
`define FN_CONT       4'h8
`define FN_DIODE      4'h9

// Settling times and clock rate
`define SETTLE_SLOW_MS 7000
`define SETTLE_MED_MS  1000
`define SETTLE_FAST_MS 100
`define CLK_KHZ        200000

`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ    2'h3

`endif

// File: core/null_avg_pkg.sv
package null_avg_pkg;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'h0,
        ST_SETTLE    = 3'h1,
        ST_WAIT_OFF  = 3'h3,
        ST_WAIT_BASE = 3'h2,
        ST_FILTER_ACTIVE_INDICATOR      = 3'h6
    } state_t;

    typedef enum logic [1:0] {
        AZ_OFF  = 2'h0,
        AZ_ONCE = 2'h1,
        AZ_ON   = 2'h2
    } az_mode_t;

    typedef enum logic [1:0] {
        BW_SLOW = 2'h0,
        BW_MED  = 2'h1,
        BW_FAST = 2'h2
    } bw_t;

    typedef struct packed {
        logic [3:0] func;
        logic [3:0] integ;
        bw_t        bw;
        az_mode_t   az;
        logic       filter_active_indicator_block;
        logic       filter_active_indicator_en;
        logic       run;
    } ctrl_t;

endpackage

// File: core/null_avg.sv
// Notes on behaviour
// - Output reading is base reading minus offset reading taken with input disconnected.
// - Auto-zero on takes a fresh offset reading before every measurement.
// - Auto-zero off takes one offset reading after function settings change, then reuses it.
// - Once selection takes one offset at the next measurement then acts as off; off issues none.
// - Auto-zero is on after reset; selections are lost at reset.
// - Integration change sets auto-zero off at 0.001 and 0.02, on otherwise.
// - Slow, medium, fast bandwidth settle 7, 1 and 0.1 seconds per AC voltage or current reading.
// - Bandwidth resets to medium, the 20 Hz lower corner.
// - Averaging window is 2 to 100 readings kept in a stack.
// - Sliding mode is first-in first-out; first reading fills the whole stack.
// - Sliding mode emits an average for every reading entering the stack.
// - Block mode averages a full stack once, then empties it and restarts.
// - Diode, continuity, frequency and period readings bypass the averager.
// - Averager resets enabled, sliding mode, window of 10.
// - Filter-active indicator follows the averager enable.
`timescale 1ns/1ps
`include "null_avg_cfg.svh"
module null_avg
    import null_avg_pkg::*;
#(
    parameter logic [31:0] SETTLE_SLOW_CYC = 32'(64'(`SETTLE_SLOW_MS) * `CLK_KHZ),
    parameter logic [31:0] SETTLE_MED_CYC  = 32'(64'(`SETTLE_MED_MS) * `CLK_KHZ),
    parameter logic [31:0] SETTLE_FAST_CYC = 32'(64'(`SETTLE_FAST_MS) * `CLK_KHZ)
) (
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               hsel_i,
    input  wire logic [31:0]        haddr_i,
    input  wire logic [1:0]         htrans_i,
    input  wire logic               hwrite_i,
    input  wire logic [2:0]         hsize_i,
    input  wire logic [31:0]        hwdata_i,
    input  wire logic               hready_i,
    output logic                    hreadyout_o,
    output logic                    hresp_o,
    output logic [31:0]             hrdata_o,
    output logic                    conv_start_o,
    output logic                    conv_zero_o,
    input  wire logic               conv_done_i,
    input  wire logic signed [23:0] conv_data_i,
    output logic                    out_valid_o,
    output logic signed [24:0]      out_data_o,
    output logic                    filter_active_indicator_o
);

    function automatic logic is_bypass(input logic [3:0] fn);
        is_bypass = (fn == `FN_FREQ) || (fn == `FN_PER) || (fn == `FN_CONT) || (fn == `FN_DIODE);
    endfunction

    function automatic logic is_ac(input logic [3:0] fn);
        is_ac = (fn == `FN_ACV) || (fn == `FN_ACI);
    endfunction

    function automatic az_mode_t az_for_integ(input logic [3:0] ig);
        az_for_integ = (ig == `INTEG_P001 || ig == `INTEG_P02) ? AZ_OFF : AZ_ON;
    endfunction

    localparam ctrl_t CTRL_RST = '{func: `FUNC_RST, integ: `INTEG_RST, bw: BW_MED, az: AZ_ON,
                                   filter_active_indicator_block: 1'b0, filter_active_indicator_en: 1'b1, run: 1'b0};

    // Bus and configuration state
    logic        wr_pend_reg, wr_pend_next;
    logic [7:0]  wr_addr_reg, wr_addr_next;
    logic [31:0] rdata_reg, rdata_next;
    ctrl_t       ctrl_reg, ctrl_next, ctrl_wr;
    logic [6:0]  win_reg, win_next, win_wr;
    logic        pend_reg, pend_next;
    logic        restart;
    logic        addr_ok;

    // Sequencer and filter state
    state_t              state_reg, state_next;
    logic [31:0]         cnt_reg, cnt_next;
    logic                start_reg, start_next, zero_reg, zero_next;
    logic signed [23:0]  off_reg, off_next;
    logic signed [24:0]  net_reg, net_next;
    logic signed [31:0]  sum_reg, sum_next, sum_new;
    logic [6:0]          ptr_reg, ptr_next;
    logic [99:0]         vld_reg, vld_next;
    logic signed [24:0]  fill_reg, fill_next, old_val;
    logic                primed_reg, primed_next;
    logic                oval_reg, oval_next;
    logic signed [24:0]  odata_reg, odata_next;
    logic                stk_we;
    logic signed [24:0]  stack [0:99];

    assign addr_ok = hsel_i && hready_i && (htrans_i == `HTRANS_NONSEQ || htrans_i == `HTRANS_SEQ);
    assign ctrl_wr = ctrl_t'(hwdata_i[`CTRL_W-1:0]);
    assign old_val = vld_reg[ptr_reg] ? stack[ptr_reg] : fill_reg;

    always_comb begin
        wr_pend_next = addr_ok && hwrite_i;
        wr_addr_next = addr_ok ? haddr_i[7:0] : wr_addr_reg;
        rdata_next   = rdata_reg;
        ctrl_next    = ctrl_reg;
        win_next     = win_reg;
        pend_next    = pend_reg;
        restart      = 1'b0;
        win_wr       = hwdata_i[`WIN_W-1:0];
        if (addr_ok && !hwrite_i) begin
            case (haddr_i[7:0])
                `OFS_CTRL:   rdata_next = 32'(ctrl_reg);
                `OFS_WINDOW: rdata_next = 32'(win_reg);
                `OFS_STATUS: rdata_next = 32'({state_reg, pend_reg, ctrl_reg.filter_active_indicator_en});
                `OFS_OFFSET: rdata_next = 32'(off_reg);
                `OFS_RESULT: rdata_next = 32'(odata_reg);
                default:     rdata_next = 32'h0000_0000;
            endcase
        end
        if (state_reg == ST_WAIT_OFF && conv_done_i) begin
            pend_next = 1'b0;
        end
        if (wr_pend_reg && wr_addr_reg == `OFS_CTRL) begin
            ctrl_next = ctrl_wr;
            if (ctrl_wr.integ != ctrl_reg.integ) begin
                ctrl_next.az = az_for_integ(ctrl_wr.integ);
            end else if (ctrl_wr.az == AZ_ONCE) begin
                ctrl_next.az = AZ_OFF;
                pend_next    = 1'b1;
            end
            if (ctrl_wr.func != ctrl_reg.func || ctrl_wr.integ != ctrl_reg.integ) begin
                pend_next = 1'b1;
            end
            restart = (ctrl_wr.filter_active_indicator_en != ctrl_reg.filter_active_indicator_en) ||
                      (ctrl_wr.filter_active_indicator_block != ctrl_reg.filter_active_indicator_block);
        end
        if (wr_pend_reg && wr_addr_reg == `OFS_WINDOW) begin
            if (win_wr < `WIN_MIN) begin
                win_next = `WIN_MIN;
            end else if (win_wr > `WIN_MAX) begin
                win_next = `WIN_MAX;
            end else begin
                win_next = win_wr;
            end
            restart = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg   <= 32'h0000_0000;
            ctrl_reg    <= CTRL_RST;
            win_reg     <= `WIN_RST;
            pend_reg    <= 1'b1;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg   <= rdata_next;
            ctrl_reg    <= ctrl_next;
            win_reg     <= win_next;
            pend_reg    <= pend_next;
        end
    end

    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        start_next  = 1'b0;
        off_next    = off_reg;
        net_next    = net_reg;
        sum_next    = sum_reg;
        ptr_next    = ptr_reg;
        vld_next    = vld_reg;
        fill_next   = fill_reg;
        primed_next = primed_reg;
        oval_next   = 1'b0;
        odata_next  = odata_reg;
        stk_we      = 1'b0;
        sum_new     = sum_reg + 32'(net_reg) - 32'(old_val);
        case (state_reg)
            ST_IDLE: begin
                if (ctrl_reg.run) begin
                    state_next = ST_SETTLE;
                    cnt_next   = 32'h0000_0000;
                    if (is_ac(ctrl_reg.func)) begin
                        case (ctrl_reg.bw)
                            BW_SLOW: cnt_next = SETTLE_SLOW_CYC;
                            BW_FAST: cnt_next = SETTLE_FAST_CYC;
                            default: cnt_next = SETTLE_MED_CYC;
                        endcase
                    end
                end
            end
            ST_SETTLE: begin
                if (cnt_reg != 32'h0000_0000) begin
                    cnt_next = cnt_reg - 32'h0000_0001;
                end else if (ctrl_reg.az == AZ_ON || pend_reg) begin
                    state_next = ST_WAIT_OFF;
                    start_next = 1'b1;
                end else begin
                    state_next = ST_WAIT_BASE;
                    start_next = 1'b1;
                end
            end
            ST_WAIT_OFF: begin
                if (conv_done_i) begin
                    off_next   = conv_data_i;
                    state_next = ST_WAIT_BASE;
                    start_next = 1'b1;
                end
            end
            ST_WAIT_BASE: begin
                if (conv_done_i) begin
                    net_next   = 25'(conv_data_i) - 25'(off_reg);
                    state_next = ST_FILTER_ACTIVE_INDICATOR;
                end
            end
            ST_FILTER_ACTIVE_INDICATOR: begin
                state_next = ST_IDLE;
                oval_next  = 1'b1;
                if (!ctrl_reg.filter_active_indicator_en || is_bypass(ctrl_reg.func)) begin
                    odata_next = net_reg;
                end else if (!ctrl_reg.filter_active_indicator_block) begin
                    if (!primed_reg) begin
                        fill_next   = net_reg;
                        vld_next    = '0;
                        sum_next    = 32'(net_reg) * 32'(win_reg);
                        ptr_next    = 7'h00;
                        primed_next = 1'b1;
                        odata_next  = net_reg;
                    end else begin
                        stk_we     = 1'b1;
                        vld_next[ptr_reg] = 1'b1;
                        sum_next   = sum_new;
                        ptr_next   = (ptr_reg == win_reg - 7'h01) ? 7'h00 : ptr_reg + 7'h01;
                        odata_next = 25'(sum_new / signed'(32'(win_reg)));
                    end
                end else begin
                    stk_we   = 1'b1;
                    sum_new  = sum_reg + 32'(net_reg);
                    sum_next = sum_new;
                    ptr_next = ptr_reg + 7'h01;
                    oval_next = 1'b0;
                    if (ptr_reg == win_reg - 7'h01) begin
                        oval_next  = 1'b1;
                        odata_next = 25'(sum_new / signed'(32'(win_reg)));
                        sum_next   = 32'h0000_0000;
                        ptr_next   = 7'h00;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (restart) begin
            sum_next    = 32'h0000_0000;
            ptr_next    = 7'h00;
            vld_next    = '0;
            primed_next = 1'b0;
        end
        zero_next = (state_next == ST_WAIT_OFF);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg  <= ST_IDLE;
            cnt_reg    <= 32'h0000_0000;
            start_reg  <= 1'b0;
            zero_reg   <= 1'b0;
            off_reg    <= 24'h00_0000;
            net_reg    <= 25'h000_0000;
            sum_reg    <= 32'h0000_0000;
            ptr_reg    <= 7'h00;
            vld_reg    <= '0;
            fill_reg   <= 25'h000_0000;
            primed_reg <= 1'b0;
            oval_reg   <= 1'b0;
            odata_reg  <= 25'h000_0000;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            start_reg  <= start_next;
            zero_reg   <= zero_next;
            off_reg    <= off_next;
            net_reg    <= net_next;
            sum_reg    <= sum_next;
            ptr_reg    <= ptr_next;
            vld_reg    <= vld_next;
            fill_reg   <= fill_next;
            primed_reg <= primed_next;
            oval_reg   <= oval_next;
            odata_reg  <= odata_next;
        end
    end

    // Reading stack
    always_ff @(posedge clk_i) begin
        if (stk_we) begin
            stack[ptr_reg] <= net_reg;
        end
    end

    assign hreadyout_o               = 1'b1;
    assign hresp_o                   = 1'b0;
    assign hrdata_o                  = rdata_reg;
    assign conv_start_o              = start_reg;
    assign conv_zero_o               = zero_reg;
    assign out_valid_o               = oval_reg;
    assign out_data_o                = odata_reg;
    assign filter_active_indicator_o = ctrl_reg.filter_active_indicator_en;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_net_sub;
        state_reg == ST_WAIT_BASE && conv_done_i |=>
            net_reg == 25'($past(conv_data_i)) - 25'(off_reg);
    endproperty
    a_net_sub: assert property (p_net_sub) else $error("net reading not base minus offset");

    property p_az_on;
        state_reg == ST_SETTLE && cnt_reg == 32'h0000_0000 && ctrl_reg.az == AZ_ON |=>
            state_reg == ST_WAIT_OFF && conv_start_o ##1 !conv_start_o;
    endproperty
    a_az_on: assert property (p_az_on) else $error("auto-zero on skipped offset");

    property p_az_off;
        state_reg == ST_SETTLE && cnt_reg == 32'h0000_0000 && ctrl_reg.az != AZ_ON && !pend_reg
            |=> state_reg == ST_WAIT_BASE;
    endproperty
    a_az_off: assert property (p_az_off) else $error("offset taken while off");

    property p_once;
        wr_pend_reg && wr_addr_reg == `OFS_CTRL && ctrl_wr.az == AZ_ONCE &&
            ctrl_wr.integ == ctrl_reg.integ |=> pend_reg && ctrl_reg.az == AZ_OFF;
    endproperty
    a_once: assert property (p_once) else $error("once did not arm offset");

    property p_integ;
        wr_pend_reg && wr_addr_reg == `OFS_CTRL && ctrl_wr.integ != ctrl_reg.integ |=>
            ctrl_reg.az == (($past(ctrl_wr.integ) == `INTEG_P001 ||
                              $past(ctrl_wr.integ) == `INTEG_P02) ? AZ_OFF : AZ_ON);
    endproperty
    a_integ: assert property (p_integ) else $error("integration change bad auto-zero");

    property p_settle;
        state_reg == ST_IDLE && ctrl_reg.run && is_ac(ctrl_reg.func) && ctrl_reg.bw == BW_SLOW
            |=> cnt_reg == SETTLE_SLOW_CYC;
    endproperty
    a_settle: assert property (p_settle) else $error("slow settle count wrong");

    property p_win;
        win_reg >= `WIN_MIN && win_reg <= `WIN_MAX;
    endproperty
    a_win: assert property (p_win) else $error("window out of range");

    property p_block;
        out_valid_o && ctrl_reg.filter_active_indicator_block && ctrl_reg.filter_active_indicator_en && !is_bypass(ctrl_reg.func)
            |-> sum_reg == 32'h0000_0000 && ptr_reg == 7'h00;
    endproperty
    a_block: assert property (p_block) else $error("block stack not emptied");

    property p_slide;
        state_reg == ST_FILTER_ACTIVE_INDICATOR && ctrl_reg.filter_active_indicator_en && !ctrl_reg.filter_active_indicator_block &&
            !is_bypass(ctrl_reg.func) |=> out_valid_o;
    endproperty
    a_slide: assert property (p_slide) else $error("sliding mode missed output");

    property p_filter_active_indicator_ind;
        wr_pend_reg && wr_addr_reg == `OFS_CTRL |=>
            filter_active_indicator_o == $past(ctrl_wr.filter_active_indicator_en);
    endproperty
    a_filter_active_indicator_ind: assert property (p_filter_active_indicator_ind) else $error("filter indicator wrong");

endmodule

// File: verification/conv_model.sv
`timescale 1ns/1ps
module conv_model (
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               start_i,
    input  wire logic               zero_i,
    input  wire logic [3:0]         lat_i,
    input  wire logic signed [23:0] base_i,
    input  wire logic signed [23:0] offset_i,
    output logic                    done_o,
    output logic signed [23:0]      data_o
);
    logic [4:0] cnt;

    // Answer lat_i + 1 cycles after a start; data churns between answers
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt    <= 5'h00;
            done_o <= 1'b0;
            data_o <= 24'h000000;
        end else begin
            done_o <= 1'b0;
            data_o <= ~data_o;
            if (start_i) begin
                cnt <= {1'b0, lat_i} + 5'h01;
            end else if (cnt == 5'h01) begin
                cnt    <= 5'h00;
                done_o <= 1'b1;
                data_o <= zero_i ? offset_i : base_i;
            end else if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
            end
        end
    end
endmodule

// File: verification/test_null_avg.sv
`timescale 1ns/1ps
`include "null_avg_cfg.svh"
module test_null_avg
    import null_avg_pkg::*;
;
    logic                    clk_i, arst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic                    conv_start_o, conv_zero_o, conv_done_i, out_valid_o;
    logic                    filter_active_indicator_o;
    logic [31:0]             haddr_i, hwdata_i, hrdata_o, rd;
    logic [1:0]              htrans_i;
    logic [2:0]              hsize_i;
    logic [3:0]              lat_v;
    logic signed [23:0]      conv_data_i, base_v, offset_v;
    logic signed [24:0]      out_data_o;
    int                      err_count = 0, cmp_count = 0, cyc = 0, zero_cnt = 0, base_cnt = 0;
    int                      zero_gap = 0, last_zero = 0;
    int                      gap [3];

    null_avg #(.SETTLE_SLOW_CYC(32'h14), .SETTLE_MED_CYC(32'h0A), .SETTLE_FAST_CYC(32'h05)) u_dut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .hrdata_o(hrdata_o), .conv_start_o(conv_start_o), .conv_zero_o(conv_zero_o),
        .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .out_valid_o(out_valid_o),
        .out_data_o(out_data_o), .filter_active_indicator_o(filter_active_indicator_o)
    );

    conv_model u_conv (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(conv_start_o), .zero_i(conv_zero_o),
        .lat_i(lat_v), .base_i(base_v), .offset_i(offset_v), .done_o(conv_done_i),
        .data_o(conv_data_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Cycle count, conversion counts, offset spacing, timeout
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (conv_start_o === 1'b1 && conv_zero_o === 1'b1) begin
            zero_cnt  <= zero_cnt + 1;
            zero_gap  <= cyc - last_zero;
            last_zero <= cyc;
        end
        if (conv_start_o === 1'b1 && conv_zero_o !== 1'b1) begin
            base_cnt <= base_cnt + 1;
        end
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] cw(input logic [3:0] f, input logic [3:0] i,
        input logic [1:0] b, input logic [1:0] a, input logic blk, input logic en,
        input logic r);
        return {17'h00000, f, i, b, a, blk, en, r};
    endfunction

    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel_i   <= 1'b1;
        haddr_i  <= a;
        hwrite_i <= w;
        htrans_i <= `HTRANS_NONSEQ;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask

    // Stop, wait for idle, then write the full control word
    task cfg(input logic [31:0] c);
        bus(1'b1, `OFS_CTRL, c & ~32'h1);
        for (int i = 0; i < 100; i++) begin
            bus(1'b0, `OFS_STATUS, 32'h0);
            if (rd[4:2] === ST_IDLE) break;
        end
        bus(1'b1, `OFS_CTRL, c);
    endtask

    task meas(input logic signed [24:0] ed, input int ez, input int eb);
        int z0;
        int b0;
        z0 = zero_cnt;
        b0 = base_cnt;
        do @(posedge clk_i); while (out_valid_o !== 1'b1);
        check("output", 32'(out_data_o), 32'(ed));
        if (ez >= 0) check("offset reads", 32'(zero_cnt - z0), 32'(ez));
        if (eb >= 0) check("base reads", 32'(base_cnt - b0), 32'(eb));
    endtask

    initial begin
        arst_n_i = 1'b0;
        hsel_i   = 1'b0;
        haddr_i  = 32'h0;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        hsize_i  = 3'h2;
        hwdata_i = 32'h0;
        lat_v    = 4'h1;
        base_v   = 24'h00044C;
        offset_v = 24'h000064;
        repeat (20) @(posedge clk_i);
        check("indicator", 32'(filter_active_indicator_o), 32'h1);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        bus(1'b0, `OFS_CTRL, 32'h0);
        check("ctrl", rd, cw(4'h0, 4'h8, 2'h1, 2'h2, 1'b0, 1'b1, 1'b0));
        bus(1'b0, `OFS_WINDOW, 32'h0);
        check("window", rd, 32'h0000000A);
        bus(1'b0, 32'h00000014, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'b1, `OFS_WINDOW, 32'h00000001);
        bus(1'b0, `OFS_WINDOW, 32'h0);
        check("window low", rd, 32'h00000002);
        bus(1'b1, `OFS_WINDOW, 32'h00000065);
        bus(1'b0, `OFS_WINDOW, 32'h0);
        check("window high", rd, 32'h00000064);
        bus(1'b1, `OFS_WINDOW, 32'h00000002);
        cfg(cw(4'h0, 4'h8, 2'h1, 2'h2, 1'b0, 1'b1, 1'b1));
        meas(25'h00003E8, 1, 1);
        base_v <= 24'h000514;
        meas(25'h000044C, 1, 1);
        base_v <= 24'h0005DC;
        meas(25'h0000514, 1, 1);
        lat_v <= 4'h4;
        cfg(cw(4'h0, 4'h8, 2'h1, 2'h0, 1'b0, 1'b1, 1'b1));
        offset_v <= 24'h00012C;
        meas(25'h0000578, 0, 1);
        meas(25'h0000578, 0, 1);
        cfg(cw(4'h1, 4'h8, 2'h1, 2'h0, 1'b0, 1'b1, 1'b1));
        meas(25'h0000514, 1, 1);
        meas(25'h00004B0, 0, 1);
        offset_v <= 24'h0000C8;
        cfg(cw(4'h1, 4'h8, 2'h1, 2'h1, 1'b0, 1'b1, 1'b1));
        bus(1'b0, `OFS_CTRL, 32'h0);
        check("once stored", 32'(rd[4:3]), 32'h0);
        meas(25'h00004E2, 1, 1);
        meas(25'h0000514, 0, 1);
        cfg(cw(4'h1, 4'h8, 2'h1, 2'h2, 1'b0, 1'b1, 1'b0));
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, `OFS_CTRL, cw(4'(i), 4'(i), 2'h1, (i == 0 || i == 2) ? 2'h2 : 2'h0,
                1'b0, 1'b1, 1'b0));
            bus(1'b0, `OFS_CTRL, 32'h0);
            check("az", 32'(rd[4:3]), (i == 0 || i == 2) ? 32'h0 : 32'h2);
        end
        for (int b = 0; b < 3; b++) begin
            cfg(cw(4'h4, 4'h9, 2'(b), 2'h2, 1'b0, 1'b1, 1'b1));
            meas(25'h0000514, 1, 1);
            meas(25'h0000514, 1, 1);
            gap[b] = zero_gap;
        end
        check("slow gap", 32'(gap[0] - gap[1]), 32'h0000000A);
        check("fast gap", 32'(gap[1] - gap[2]), 32'h00000005);
        base_v   <= 24'h0002BC;
        offset_v <= 24'h000064;
        cfg(cw(4'h0, 4'h9, 2'h1, 2'h2, 1'b1, 1'b1, 1'b0));
        bus(1'b1, `OFS_WINDOW, 32'h00000003);
        bus(1'b1, `OFS_CTRL, cw(4'h0, 4'h9, 2'h1, 2'h2, 1'b1, 1'b1, 1'b1));
        meas(25'h0000258, 3, 3);
        meas(25'h0000258, 3, 3);
        for (int f = 6; f < 10; f++) begin
            cfg(cw(4'(f), 4'h9, 2'h1, 2'h2, 1'b1, 1'b1, 1'b1));
            meas(25'h0000258, 1, 1);
        end
        cfg(cw(4'h0, 4'h9, 2'h1, 2'h2, 1'b1, 1'b0, 1'b1));
        @(posedge clk_i);
        check("indicator off", 32'(filter_active_indicator_o), 32'h0);
        meas(25'h0000258, 1, 1);
        bus(1'b1, `OFS_CTRL, cw(4'h0, 4'h9, 2'h1, 2'h2, 1'b1, 1'b1, 1'b0));
        @(posedge clk_i);
        check("indicator on", 32'(filter_active_indicator_o), 32'h1);
        tally_and_finish();
    end
endmodule
